// *** design/dee_pkg.sv ***
package dee_pkg;
    // Register offsets
    localparam logic [7:0] DEE_OFS_DATA = 8'h08;
    localparam logic [7:0] DEE_OFS_ADDR = 8'h09;
    localparam logic [7:0] DEE_OFS_CTRL = 8'h88;
    localparam logic [7:0] DEE_OFS_UNLOCK = 8'h89;
    // Control field positions
    localparam int DEE_BIT_RD = 0;
    localparam int DEE_BIT_WR = 1;
    localparam int DEE_BIT_GATE = 2;
    localparam int DEE_BIT_ERR = 3;
    localparam int DEE_BIT_DONE = 4;
    // Unlock keys
    localparam logic [7:0] DEE_KEY1 = 8'h55;
    localparam logic [7:0] DEE_KEY2 = 8'haa;
    // Reset values
    localparam logic [7:0] DEE_ADDR_RST = 8'h00;
    localparam logic [7:0] DEE_DATA_RST = 8'h00;
    // Array depth
    localparam int DEE_DEPTH = 64;
    // Timing
    localparam int DEE_CLK_MHZ = 100;
    localparam int DEE_WRITE_US = 40;
    localparam int DEE_WRITE_CYC = DEE_WRITE_US * DEE_CLK_MHZ;
    localparam int DEE_PUT_MS = 72;
    localparam int DEE_PUT_CYC = DEE_PUT_MS * 1000 * DEE_CLK_MHZ;
    // Unlock sequence states
    typedef enum logic [1:0] {
        DEE_UL_IDLE = 2'b00,
        DEE_UL_KEY1 = 2'b01,
        DEE_UL_ARMED = 2'b10
    } dee_ul_t;
endpackage : dee_pkg

// *** design/dee_array.sv ***
`timescale 1ns/10ps
// Byte array with combinational read and erase-then-program write
module dee_array (
    input wire logic sys_clk,
    input wire logic [5:0] rd_addr,
    output logic [7:0] rd_data,
    input wire logic erase_en,
    input wire logic prog_en,
    input wire logic [5:0] wr_addr,
    input wire logic [7:0] wr_data
);
    // Storage cells, left unreset like real nonvolatile contents
    logic [7:0] cell_mem [dee_pkg::DEE_DEPTH];

    // Erase forces ones, program lays the new byte over it
    always_ff @(posedge sys_clk) begin
        if (prog_en) begin
            cell_mem[wr_addr] <= wr_data;
        end else if (erase_en) begin
            cell_mem[wr_addr] <= 8'hff;
        end
    end

    assign rd_data = cell_mem[rd_addr];
endmodule : dee_array

// *** design/dee_ctrl.sv ***
`timescale 1ns/10ps
// Data nonvolatile memory access controller
module dee_ctrl #(
    parameter int WRITE_CYC = dee_pkg::DEE_WRITE_CYC,
    parameter int PUT_CYC = dee_pkg::DEE_PUT_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic por_n,
    input wire logic master_clear_reset,
    input wire logic watchdog_timer,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic done_irq_en,
    output logic irq_req,
    output logic write_busy
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [7:0] nv_address_reg; // Target address
    logic [7:0] nv_data_reg; // Data byte
    logic rd_start_reg; // Read start bit
    logic wr_start_reg; // Write start bit
    logic write_enable_gate; // Write gate
    logic write_abort_error; // Abort flag
    logic write_done_flag; // Done flag
    logic [31:0] wr_cnt_reg; // Write timer
    logic [31:0] put_cnt_reg; // Power-up timer
    logic put_run_reg; // Power-up timer running
    logic mcr_s1, mcr_s2, wdog_s1, wdog_s2; // Synchronisers
    logic rst_evt; // Sync reset event
    logic [7:0] arr_rdata; // Array read byte
    logic addr_ok; // Address inside array
    logic erase_en, prog_en; // Array strobes
    logic start_ok; // Legal write start
    logic wr_finish; // Write timer expiry
    logic [7:0] rdata_next; // Read mux
    logic irq_next; // Interrupt next value
    dee_pkg::dee_ul_t ul_reg;
    // One decode used by several processes
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////
    // Reset pins are asynchronous to core: two flops first
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mcr_s1 <= 1'b0;
            mcr_s2 <= 1'b0;
            wdog_s1 <= 1'b0;
            wdog_s2 <= 1'b0;
        end else begin
            mcr_s1 <= master_clear_reset;
            mcr_s2 <= mcr_s1;
            wdog_s1 <= watchdog_timer;
            wdog_s2 <= wdog_s1;
        end
    end
    assign rst_evt = mcr_s2 | wdog_s2;

    ////////////////////////////////////////////////////////////////////////
    // Power-up timer: runs only after por_n, never restarts on other resets
    always_ff @(posedge sys_clk or negedge por_n) begin
        if (!por_n) begin
            put_cnt_reg <= 32'h0;
            put_run_reg <= 1'b1;
        end else if (put_run_reg) begin
            if (put_cnt_reg == 32'(PUT_CYC - 1)) begin
                put_run_reg <= 1'b0;
            end
            put_cnt_reg <= put_cnt_reg + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode: upper bits take part, so 40h..ffh miss the array
    assign addr_ok = (nv_address_reg[7:6] == 2'b00);

    // Start is legal only armed, gated, idle and past power-up
    assign start_ok = reg_wr && hit(reg_addr, dee_pkg::DEE_OFS_CTRL)
        && reg_wdata[dee_pkg::DEE_BIT_WR] && !wr_start_reg
        && (ul_reg == dee_pkg::DEE_UL_ARMED)
        && write_enable_gate
        && !put_run_reg && !rst_evt;

    assign wr_finish = wr_start_reg && !rst_evt
        && (wr_cnt_reg == 32'(WRITE_CYC - 1));

    ////////////////////////////////////////////////////////////////////////
    // Unlock tracker: any other bus write breaks the sequence
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ul_reg <= dee_pkg::DEE_UL_IDLE;
        end else if (reg_wr) begin
            unique case (ul_reg)
                dee_pkg::DEE_UL_IDLE: begin
                    ul_reg <= (hit(reg_addr, dee_pkg::DEE_OFS_UNLOCK)
                        && reg_wdata == dee_pkg::DEE_KEY1)
                        ? dee_pkg::DEE_UL_KEY1 : dee_pkg::DEE_UL_IDLE;
                end
                dee_pkg::DEE_UL_KEY1: begin
                    ul_reg <= (hit(reg_addr, dee_pkg::DEE_OFS_UNLOCK)
                        && reg_wdata == dee_pkg::DEE_KEY2)
                        ? dee_pkg::DEE_UL_ARMED : dee_pkg::DEE_UL_IDLE;
                end
                dee_pkg::DEE_UL_ARMED: begin
                    ul_reg <= dee_pkg::DEE_UL_IDLE;
                end
                default: begin
                    ul_reg <= dee_pkg::DEE_UL_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address register: untouched by any reset after power-up
    always_ff @(posedge sys_clk or negedge por_n) begin
        if (!por_n) begin
            nv_address_reg <= dee_pkg::DEE_ADDR_RST;
        end else if (reg_wr && hit(reg_addr, dee_pkg::DEE_OFS_ADDR)) begin
            nv_address_reg <= reg_wdata;
        end
    end

    // Data register: software write or a read fetch, else holds
    always_ff @(posedge sys_clk or negedge por_n) begin
        if (!por_n) begin
            nv_data_reg <= dee_pkg::DEE_DATA_RST;
        end else if (reg_wr && hit(reg_addr, dee_pkg::DEE_OFS_DATA)) begin
            nv_data_reg <= reg_wdata;
        end else if (rd_start_reg) begin
            nv_data_reg <= addr_ok ? arr_rdata : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read start: set-only, clears itself one cycle later
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_start_reg <= 1'b0;
        end else if (rd_start_reg) begin
            rd_start_reg <= 1'b0;
        end else if (reg_wr && hit(reg_addr, dee_pkg::DEE_OFS_CTRL)
            && reg_wdata[dee_pkg::DEE_BIT_RD] && !wr_start_reg) begin
            rd_start_reg <= 1'b1;
        end
    end

    // Write start and timer; gate changes never stop it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_start_reg <= 1'b0;
            wr_cnt_reg <= 32'h0;
        end else if (wr_start_reg) begin
            if (rst_evt || wr_finish) begin
                wr_start_reg <= 1'b0;
                wr_cnt_reg <= 32'h0;
            end else begin
                wr_cnt_reg <= wr_cnt_reg + 32'h1;
            end
        end else if (start_ok) begin
            wr_start_reg <= 1'b1;
            wr_cnt_reg <= 32'h0;
        end
    end

    // Erase on first timed cycle, program on the last
    assign erase_en = wr_start_reg && (wr_cnt_reg == 32'h0) && addr_ok;
    assign prog_en = wr_finish && addr_ok;

    ////////////////////////////////////////////////////////////////////////
    // Gate: cleared by rst_n or software, never by a write ending
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            write_enable_gate <= 1'b0;
        end else if (reg_wr && hit(reg_addr, dee_pkg::DEE_OFS_CTRL)) begin
            write_enable_gate <= reg_wdata[dee_pkg::DEE_BIT_GATE];
        end
    end

    // Abort error: set by a reset mid-write, cleared by a clean finish
    always_ff @(posedge sys_clk or negedge por_n) begin
        if (!por_n) begin
            write_abort_error <= 1'b0;
        end else if (wr_start_reg && rst_evt) begin
            write_abort_error <= 1'b1;
        end else if (wr_finish) begin
            write_abort_error <= 1'b0;
        end else if (reg_wr && hit(reg_addr, dee_pkg::DEE_OFS_CTRL)) begin
            write_abort_error <= reg_wdata[dee_pkg::DEE_BIT_ERR];
        end
    end

    // Done flag: set wins over a software clear in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            write_done_flag <= 1'b0;
        end else if (wr_finish) begin
            write_done_flag <= 1'b1;
        end else if (reg_wr && hit(reg_addr, dee_pkg::DEE_OFS_CTRL)) begin
            write_done_flag <= reg_wdata[dee_pkg::DEE_BIT_DONE];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux, registered so outputs come from flops
    always_comb begin
        rdata_next = 8'h00;
        if (reg_rd) begin
            if (hit(reg_addr, dee_pkg::DEE_OFS_DATA)) begin
                rdata_next = nv_data_reg;
            end else if (hit(reg_addr, dee_pkg::DEE_OFS_ADDR)) begin
                rdata_next = nv_address_reg;
            end else if (hit(reg_addr, dee_pkg::DEE_OFS_CTRL)) begin
                rdata_next = {3'b000, write_done_flag, write_abort_error,
                    write_enable_gate, wr_start_reg, rd_start_reg};
            end else begin
                rdata_next = 8'h00;
            end
        end
    end
    assign irq_next = write_done_flag && done_irq_en;

    // Output flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            irq_req <= 1'b0;
            write_busy <= 1'b0;
        end else begin
            reg_rdata <= rdata_next;
            irq_req <= irq_next;
            write_busy <= wr_start_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Array
    dee_array dee_array_i (
        .sys_clk(sys_clk),
        .rd_addr(nv_address_reg[5:0]),
        .rd_data(arr_rdata),
        .erase_en(erase_en),
        .prog_en(prog_en),
        .wr_addr(nv_address_reg[5:0]),
        .wr_data(nv_data_reg)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_key1;
        reg_wr && hit(reg_addr, dee_pkg::DEE_OFS_UNLOCK)
            && reg_wdata == dee_pkg::DEE_KEY1
            && ul_reg == dee_pkg::DEE_UL_IDLE;
    endsequence
    sequence s_key2;
        reg_wr && hit(reg_addr, dee_pkg::DEE_OFS_UNLOCK)
            && reg_wdata == dee_pkg::DEE_KEY2;
    endsequence

    property p_unlock_arms;
        @(posedge sys_clk) disable iff (!rst_n)
        s_key1 ##1 !reg_wr ##1 s_key2 |=> ul_reg == dee_pkg::DEE_UL_ARMED;
    endproperty
    a_unlock_arms: assert property (p_unlock_arms)
        else $error("unlock sequence did not arm");

    property p_start_needs_arm;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(wr_start_reg) |-> $past(ul_reg) == dee_pkg::DEE_UL_ARMED
            && $past(write_enable_gate);
    endproperty
    a_start_needs_arm: assert property (p_start_needs_arm)
        else $error("write started without arm and gate");

    property p_read_next;
        @(posedge sys_clk) disable iff (!rst_n)
        rd_start_reg && addr_ok && !(reg_wr
            && hit(reg_addr, dee_pkg::DEE_OFS_DATA))
            |=> nv_data_reg == $past(arr_rdata) && !rd_start_reg;
    endproperty
    a_read_next: assert property (p_read_next)
        else $error("read data not loaded next cycle");

    property p_done_sets;
        @(posedge sys_clk) disable iff (!rst_n)
        wr_finish |=> write_done_flag && !wr_start_reg
            && !write_abort_error;
    endproperty
    a_done_sets: assert property (p_done_sets)
        else $error("done flag not set at write end");

    property p_abort_sets;
        @(posedge sys_clk) disable iff (!rst_n)
        wr_start_reg && rst_evt |=> write_abort_error && !wr_start_reg;
    endproperty
    a_abort_sets: assert property (p_abort_sets)
        else $error("abort error not set");

    property p_gate_hw_keep;
        @(posedge sys_clk) disable iff (!rst_n)
        $fell(write_enable_gate) |-> $past(reg_wr)
            && $past(hit(reg_addr, dee_pkg::DEE_OFS_CTRL));
    endproperty
    a_gate_hw_keep: assert property (p_gate_hw_keep)
        else $error("gate cleared without software write");

    property p_ctrl_upper_zero;
        @(posedge sys_clk) disable iff (!rst_n)
        reg_rd && hit(reg_addr, dee_pkg::DEE_OFS_CTRL)
            |=> reg_rdata[7:5] == 3'b000;
    endproperty
    a_ctrl_upper_zero: assert property (p_ctrl_upper_zero)
        else $error("control upper bits not zero");

    property p_unlock_reads_zero;
        @(posedge sys_clk) disable iff (!rst_n)
        reg_rd && hit(reg_addr, dee_pkg::DEE_OFS_UNLOCK)
            |=> reg_rdata == 8'h00;
    endproperty
    a_unlock_reads_zero: assert property (p_unlock_reads_zero)
        else $error("unlock port read nonzero");

    property p_irq_follows;
        @(posedge sys_clk) disable iff (!rst_n)
        write_done_flag && done_irq_en |=> irq_req;
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("interrupt not raised");

    property p_put_blocks;
        @(posedge sys_clk) disable iff (!rst_n)
        put_run_reg |=> !$rose(wr_start_reg);
    endproperty
    a_put_blocks: assert property (p_put_blocks)
        else $error("write started during power-up timer");
endmodule : dee_ctrl

// *** sim/dee_mem_model.sv ***
`timescale 1ns/10ps
// Expected image of the byte array behind the controller
module dee_mem_model (
    input wire logic sys_clk,
    input wire logic upd,
    input wire logic [5:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [5:0] rd_addr,
    output logic [7:0] rd_data
);
    // Only the implemented locations exist; six address bits reach them
    logic [7:0] mem_reg [0:63];

    ////////////////////////////////////////////////////////////////////////
    // Whole-byte replace: old contents never leak into the new value
    always_ff @(posedge sys_clk) begin
        if (upd) begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    // Combinational look-up, used by the bench for expected read data
    assign rd_data = mem_reg[rd_addr];
endmodule : dee_mem_model

// *** sim/data_eeprom_access_ctrl_tb.sv ***
`timescale 1ns/10ps
// Register-level bench for the nonvolatile access controller
module data_eeprom_access_ctrl_tb;
    localparam int WCYC = 8; // Shortened write time
    localparam int PCYC = 40; // Shortened power-up hold
    logic sys_clk, rst_n, por_n, mcr, wdog, reg_wr, reg_rd, irq_en;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, q, exp_q;
    logic irq_req, write_busy, upd;
    logic [5:0] m_waddr, m_raddr;
    logic [7:0] m_wdata, m_q;
    int errors, checks, n, i;

    dee_ctrl #(.WRITE_CYC(WCYC), .PUT_CYC(PCYC)) dee_ctrl_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .por_n(por_n),
        .master_clear_reset(mcr), .watchdog_timer(wdog),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .done_irq_en(irq_en), .irq_req(irq_req), .write_busy(write_busy)
    );
    dee_mem_model dee_mem_model_i (
        .sys_clk(sys_clk), .upd(upd), .wr_addr(m_waddr),
        .wr_data(m_wdata), .rd_addr(m_raddr), .rd_data(m_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // 100 MHz core clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Verdict; every exit of the run comes through here
    task automatic test_done();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done

    // Byte compare, an unknown bit matches only an unknown expected bit
    task automatic cmp(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask : cmp

    // One-cycle write strobe, inputs move on falling edges only
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask : wr

    // Read data is registered, so it is taken one edge after the strobe
    task automatic chk(input string nm, input logic [7:0] a,
                       input logic [7:0] e);
        @(negedge sys_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        cmp(nm, e, reg_rdata);
    endtask : chk

    // Mirror a write that the controller is expected to perform
    task automatic mm_put(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        upd = 1'b1;
        m_waddr = a[5:0];
        m_wdata = d;
        @(negedge sys_clk);
        upd = 1'b0;
    endtask : mm_put

    // Keys then start; any other write in between spoils it
    task automatic start_seq(input logic [7:0] c);
        wr(8'h89, 8'h55);
        wr(8'h89, 8'haa);
        wr(8'h88, c);
    endtask : start_seq

    // Operands first, gate next, then the unlock sequence
    task automatic ee_write(input logic [7:0] a, input logic [7:0] d);
        wr(8'h09, a);
        wr(8'h08, d);
        wr(8'h88, 8'h04);
        start_seq(8'h06);
    endtask : ee_write

    // Start a read and compare the data register with the model image
    task automatic ee_read(input logic [7:0] a);
        wr(8'h09, a);
        wr(8'h88, 8'h01); // gate dropped while only reading
        m_raddr = a[5:0];
        #1;
        exp_q = (a[7:6] == 2'b00) ? m_q : 8'h00;
        chk("read_data", 8'h08, exp_q);
    endtask : ee_read

    // Count busy cycles; a write that never ends is a failure
    task automatic wait_idle(output int cnt);
        int k;
        cnt = 0;
        for (k = 0; k < 40; k++) begin
            @(negedge sys_clk);
            if (write_busy === 1'b1) cnt++;
            else if (cnt > 0) break;
        end
        if (write_busy !== 1'b0) begin
            errors++;
            $display("mismatch write_busy exp 0 got %b", write_busy);
            test_done();
        end
    endtask : wait_idle

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rst_n, por_n, mcr, wdog, reg_wr, reg_rd, irq_en, upd} = 8'h00;
        {reg_addr, reg_wdata, m_waddr, m_raddr, m_wdata} = 36'h0;
        errors = 0;
        checks = 0;
        repeat (20) @(negedge sys_clk);
        rst_n = 1'b1;
        por_n = 1'b1;
        // Gate and flags come out of power-up cleared
        chk("ctrl_por", 8'h88, 8'h00);
        // Power-up timer still running: write must not start
        ee_write(8'h05, 8'h11);
        wait_idle(n);
        cmp("put_busy", 8'h00, n[7:0]);
        repeat (PCYC) @(negedge sys_clk);
        wr(8'h88, 8'he0);
        chk("ctrl_rst", 8'h88, 8'h00);
        chk("unlock_rd", 8'h89, 8'h00);
        irq_en = 1'b1;
        // Good writes, lowest and highest location included
        for (i = 0; i < 3; i++) begin
            q = (i == 0) ? 8'h00 : (i == 1) ? 8'h3f : 8'h05;
            exp_q = (i == 0) ? 8'h0f : (i == 1) ? 8'ha5 : 8'h3c;
            ee_write(q, exp_q);
            wait_idle(n);
            cmp("busy_cycles", 8'(WCYC), n[7:0]);
            chk("ctrl_done", 8'h88, 8'h14);
            @(negedge sys_clk);
            cmp("irq_on", 8'h01, {7'h00, irq_req});
            mm_put(q, exp_q);
            ee_read(q);
        end
        // Done cleared by software write, interrupt follows
        repeat (2) @(negedge sys_clk);
        cmp("irq_off", 8'h00, {7'h00, irq_req});
        // Data register holds until read or written
        chk("data_hold", 8'h08, 8'h3c);
        wr(8'h08, 8'h5a);
        chk("data_sw", 8'h08, 8'h5a);
        // Start refused without gate
        wr(8'h88, 8'h00);
        start_seq(8'h02);
        wait_idle(n);
        cmp("nogate_busy", 8'h00, n[7:0]);
        // Broken unlock sequences
        for (i = 0; i < 3; i++) begin
            wr(8'h88, 8'h04);
            if (i == 1) wr(8'h89, 8'haa);
            else wr(8'h89, 8'h55);
            if (i == 0) wr(8'h08, 8'h99);
            if (i == 1) wr(8'h89, 8'h55);
            else wr(8'h89, 8'haa);
            if (i == 2) wr(8'h09, 8'h05);
            wr(8'h88, 8'h06);
            wait_idle(n);
            cmp("badseq_busy", 8'h00, n[7:0]);
            ee_read(8'h05);
        end
        // Out-of-range address must not alias onto location 05h
        ee_write(8'h45, 8'hc3);
        wait_idle(n);
        ee_read(8'h45);
        ee_read(8'h05);
        // Gate cleared mid-write: write still completes
        ee_write(8'h20, 8'h81);
        wr(8'h88, 8'h00);
        chk("ctrl_busy", 8'h88, 8'h02);
        wait_idle(n);
        chk("ctrl_fin", 8'h88, 8'h10);
        // Done still set, enable low: request must drop
        irq_en = 1'b0;
        @(negedge sys_clk);
        cmp("irq_mask", 8'h00, {7'h00, irq_req});
        irq_en = 1'b1;
        mm_put(8'h20, 8'h81);
        ee_read(8'h20);
        // Abort by external reset, then by watchdog reset
        for (i = 0; i < 2; i++) begin
            q = 8'h10 + 8'(i);
            exp_q = 8'h70 + 8'(i);
            ee_write(q, exp_q);
            repeat (3) @(negedge sys_clk);
            if (i == 0) mcr = 1'b1;
            else wdog = 1'b1;
            repeat (4) @(negedge sys_clk);
            rst_n = 1'b0;
            repeat (2) @(negedge sys_clk);
            {mcr, wdog} = 2'b00;
            rst_n = 1'b1;
            chk("ctrl_abort", 8'h88, 8'h08);
            chk("addr_kept", 8'h09, q);
            chk("data_kept", 8'h08, exp_q);
            ee_write(q, exp_q);
            wait_idle(n);
            chk("ctrl_clean", 8'h88, 8'h14);
            mm_put(q, exp_q);
            ee_read(q);
        end
        test_done();
    end
endmodule : data_eeprom_access_ctrl_tb
